// ### gpio_pkg.sv
// Shared constants and carrier types for the general-purpose port block.
package gpio_pkg;

	localparam int PORTS = 8;
	localparam int PINS = 31;
	localparam int CHANNELS = 8;
	localparam int GROUPS = 2;
	localparam int LANES = 4;
	localparam int DATA_W = 32;
	localparam int VIEW_W = 4;
	localparam int IDX_W = 3;

	// Register views, selected by the view field of an access.
	localparam logic [3:0] V_DIR = 4'h0;
	localparam logic [3:0] V_MASK = 4'h1;
	localparam logic [3:0] V_PIN = 4'h2;
	localparam logic [3:0] V_MPIN = 4'h3;
	localparam logic [3:0] V_OUT = 4'h4;
	localparam logic [3:0] V_SET = 4'h5;
	localparam logic [3:0] V_CLR = 4'h6;
	localparam logic [3:0] V_ICFG = 4'h7;
	localparam logic [3:0] V_ICLR = 4'h8;
	localparam logic [3:0] V_G0EN = 4'h9;
	localparam logic [3:0] V_G1EN = 4'hA;
	localparam logic [3:0] V_G0POL = 4'hB;
	localparam logic [3:0] V_G1POL = 4'hC;
	localparam logic [3:0] V_GCTL = 4'hD;
	localparam logic [3:0] V_ISTAT = 4'hE;

	// Field layout of a pin interrupt channel configuration word.
	localparam int ICFG_PIN_LSB = 0;
	localparam int ICFG_PORT_LSB = 5;
	localparam int ICFG_LEVEL_BIT = 8;
	localparam int ICFG_HIGH_BIT = 9;
	localparam int ICFG_W = 10;

	// Reset values.
	localparam logic [PINS-1:0] DIR_RST = 31'h00000000;
	localparam logic [PINS-1:0] OUT_RST = 31'h00000000;
	localparam logic [PINS-1:0] MASK_RST = 31'h00000000;
	localparam logic [ICFG_W-1:0] ICFG_RST = 10'h000;

	// One register access from the system side.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [VIEW_W-1:0] view;
		logic [IDX_W-1:0] idx;
		logic [LANES-1:0] be;
		logic [DATA_W-1:0] wdata;
	} acc_req_t;

	// Read answer, valid one cycle after the read is taken.
	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] rdata;
	} acc_rsp_t;

endpackage : gpio_pkg

// ### pin_irq_channel.sv
// One pin interrupt channel: edge or level detection of a selected pin.
`timescale 1ns/1ps
module pin_irq_channel (
	input wire logic clk,
	input wire logic rst,
	input wire logic level_in,
	input wire logic level_mode,
	input wire logic active_high,
	input wire logic clr,
	output logic irq,
	output logic pending
);

	logic prev_reg;
	logic flag_reg;
	logic irq_reg;
	logic active;
	logic prev_active;
	logic edge_hit;
	logic flag_next;

	// Polarity folds both modes onto an active-high view of the pin.
	assign active = active_high ? level_in : ~level_in;
	assign prev_active = active_high ? prev_reg : ~prev_reg;
	assign edge_hit = active & ~prev_active;
	// An edge arriving with the clear is kept, so no event is lost.
	assign flag_next = edge_hit | (flag_reg & ~clr);

	// Level mode follows the pin; edge mode holds until cleared.
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_reg <= 1'b0;
			flag_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			prev_reg <= level_in;
			flag_reg <= flag_next;
			irq_reg <= level_mode ? active : flag_next;
		end
	end

	assign irq = irq_reg;
	assign pending = flag_reg;

endmodule : pin_irq_channel

// ### fast_gpio_port.sv
// General-purpose port block: eight ports, direct access, pin interrupts.
//
// Operation
// - Eight ports, each with up to 31 individually controlled pins.
// - Unassigned pins follow port registers; direction set at runtime.
// - Set and clear views change chosen output bits in one write.
// - Reads return output latch or live pin level, by view.
// - After reset pins are inputs; pull-up on, input buffer off.
// - Pin level reads as real only once its input buffer is on.
// - Per-port mask; masked view writes leave masked bits unchanged.
// - Byte, half-word and word writes update only addressed lanes.
// - A single write sets a whole port output value at once.
// - Each pin direction has its own bit; mixing allowed.
// - Eight pin interrupts, any pin each, edge or level sensitive.
// - Two group interrupts, triggered by chosen pins of every port.
// - Registers sit on the fast access port, one-cycle latency.
`timescale 1ns/1ps
module fast_gpio_port (
	input wire logic clk,
	input wire logic rst,
	input gpio_pkg::acc_req_t req,
	output gpio_pkg::acc_rsp_t rsp,
	input wire logic [7:0][30:0] pin_in,
	input wire logic [7:0][30:0] pin_function_select_cfg,
	input wire logic [7:0][30:0] input_buffer_en,
	output logic [7:0][30:0] pin_out,
	output logic [7:0][30:0] pin_oe,
	output logic [7:0] pin_irq,
	output logic [1:0] group_irq
);

	localparam int P = gpio_pkg::PINS;
	localparam int C = gpio_pkg::CHANNELS;

	logic [7:0][30:0] dir_reg;
	logic [7:0][30:0] out_reg;
	logic [7:0][30:0] mask_reg;
	logic [7:0][30:0] oe_reg;
	logic [7:0][30:0] g0en_reg;
	logic [7:0][30:0] g1en_reg;
	logic [7:0][30:0] g0pol_reg;
	logic [7:0][30:0] g1pol_reg;
	logic [1:0] gand_reg;
	logic [1:0] grp_reg;
	logic [C-1:0][gpio_pkg::ICFG_W-1:0] icfg_reg;
	gpio_pkg::acc_rsp_t rsp_reg;

	logic [7:0][30:0] pin_lvl;
	logic [P-1:0] lane_mask;
	logic [P-1:0] wd;
	logic [P-1:0] cur_out;
	logic [P-1:0] cur_mask;
	logic [P-1:0] out_next;
	logic [P-1:0] rd_word;
	logic [P*8-1:0] lvl_flat;
	logic [C-1:0] ch_irq;
	logic [C-1:0] ch_pend;
	logic [C-1:0] ch_clr;
	logic [C-1:0] ch_lvl;
	logic [7:0] g0_hit;
	logic [7:0] g1_hit;
	logic [7:0] g0_ok;
	logic [7:0] g1_ok;
	logic [1:0] grp_next;
	logic wr_en;
	logic out_wr;

	// Lane enables widened to bits; bit 31 has no pin behind it.
	assign lane_mask = {{7{req.be[3]}}, {8{req.be[2]}},
		{8{req.be[1]}}, {8{req.be[0]}}};
	assign wd = req.wdata[P-1:0];
	assign wr_en = req.wr;
	assign cur_out = out_reg[req.idx];
	assign cur_mask = mask_reg[req.idx];

	// A pin reads low until its input buffer is switched on.
	assign pin_lvl = pin_in & input_buffer_en;

	// Next output latch for the addressed port, by write view.
	always_comb begin
		out_next = cur_out;
		out_wr = 1'b0;
		case (req.view)
			gpio_pkg::V_OUT: begin
				out_next = (cur_out & ~lane_mask) | (wd & lane_mask);
				out_wr = wr_en;
			end
			gpio_pkg::V_MPIN: begin
				out_next = (cur_out & (~lane_mask | cur_mask))
					| (wd & lane_mask & ~cur_mask);
				out_wr = wr_en;
			end
			gpio_pkg::V_SET: begin
				out_next = cur_out | (wd & lane_mask);
				out_wr = wr_en;
			end
			gpio_pkg::V_CLR: begin
				out_next = cur_out & ~(wd & lane_mask);
				out_wr = wr_en;
			end
			default: begin
				out_next = cur_out;
				out_wr = 1'b0;
			end
		endcase
	end

	// Read multiplexer; set and clear views return the latch.
	always_comb begin
		rd_word = '0;
		case (req.view)
			gpio_pkg::V_DIR: rd_word = dir_reg[req.idx];
			gpio_pkg::V_MASK: rd_word = cur_mask;
			gpio_pkg::V_PIN: rd_word = pin_lvl[req.idx];
			gpio_pkg::V_MPIN: rd_word = pin_lvl[req.idx] & ~cur_mask;
			gpio_pkg::V_OUT: rd_word = cur_out;
			gpio_pkg::V_SET: rd_word = cur_out;
			gpio_pkg::V_CLR: rd_word = cur_out;
			gpio_pkg::V_ICFG: rd_word = P'(icfg_reg[req.idx]);
			gpio_pkg::V_ISTAT: rd_word = P'(ch_pend);
			gpio_pkg::V_G0EN: rd_word = g0en_reg[req.idx];
			gpio_pkg::V_G1EN: rd_word = g1en_reg[req.idx];
			gpio_pkg::V_G0POL: rd_word = g0pol_reg[req.idx];
			gpio_pkg::V_G1POL: rd_word = g1pol_reg[req.idx];
			gpio_pkg::V_GCTL: rd_word = P'(gand_reg);
			default: rd_word = '0;
		endcase
	end

	// Port registers; reset leaves every pin an input.
	always_ff @(posedge clk) begin
		if (rst) begin
			dir_reg <= {gpio_pkg::PORTS{gpio_pkg::DIR_RST}};
			out_reg <= {gpio_pkg::PORTS{gpio_pkg::OUT_RST}};
			mask_reg <= {gpio_pkg::PORTS{gpio_pkg::MASK_RST}};
		end else begin
			if (wr_en && req.view == gpio_pkg::V_DIR) begin
				dir_reg[req.idx] <= (dir_reg[req.idx] & ~lane_mask)
					| (wd & lane_mask);
			end
			if (wr_en && req.view == gpio_pkg::V_MASK) begin
				mask_reg[req.idx] <= (cur_mask & ~lane_mask)
					| (wd & lane_mask);
			end
			if (out_wr) begin
				out_reg[req.idx] <= out_next;
			end
		end
	end

	// Group and pin interrupt channel configuration registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			g0en_reg <= '0;
			g1en_reg <= '0;
			g0pol_reg <= '0;
			g1pol_reg <= '0;
			gand_reg <= '0;
			icfg_reg <= {C{gpio_pkg::ICFG_RST}};
		end else if (wr_en) begin
			case (req.view)
				gpio_pkg::V_G0EN: g0en_reg[req.idx] <= wd & lane_mask
					| g0en_reg[req.idx] & ~lane_mask;
				gpio_pkg::V_G1EN: g1en_reg[req.idx] <= wd & lane_mask
					| g1en_reg[req.idx] & ~lane_mask;
				gpio_pkg::V_G0POL: g0pol_reg[req.idx] <= wd & lane_mask
					| g0pol_reg[req.idx] & ~lane_mask;
				gpio_pkg::V_G1POL: g1pol_reg[req.idx] <= wd & lane_mask
					| g1pol_reg[req.idx] & ~lane_mask;
				gpio_pkg::V_GCTL: if (req.be[0]) gand_reg <= wd[1:0];
				gpio_pkg::V_ICFG: if (req.be[0] && req.be[1]) begin
					icfg_reg[req.idx] <= wd[gpio_pkg::ICFG_W-1:0];
				end
				default: gand_reg <= gand_reg;
			endcase
		end
	end

	// Pin drivers; a pin given to a peripheral is never driven here.
	// Output enable lags a direction write by one clock.
	always_ff @(posedge clk) begin
		if (rst) begin
			oe_reg <= '0;
		end else begin
			oe_reg <= dir_reg & pin_function_select_cfg;
		end
	end

	// Read answer one clock after the request, straight on the fast port.
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.valid <= req.rd;
			// Data holds between reads, so a late sampler still sees it.
			if (req.rd) begin
				rsp_reg.rdata <= {1'b0, rd_word};
			end
		end
	end

	assign lvl_flat = pin_lvl;

	// Pin interrupt channels, each picking any pin of any port.
	genvar ch;
	generate
		for (ch = 0; ch < C; ch = ch + 1) begin : g_ch
			logic [4:0] sel_pin;
			logic [2:0] sel_port;
			assign sel_pin = icfg_reg[ch][gpio_pkg::ICFG_PIN_LSB +: 5];
			assign sel_port = icfg_reg[ch][gpio_pkg::ICFG_PORT_LSB +: 3];
			assign ch_lvl[ch] = (sel_pin < 5'(P)) ?
				lvl_flat[8'(sel_port) * 8'(P) + 8'(sel_pin)] : 1'b0;
			assign ch_clr[ch] = wr_en && req.view == gpio_pkg::V_ICLR
				&& req.be[0] && req.wdata[ch];
			pin_irq_channel u_chan (
				.clk(clk),
				.rst(rst),
				.level_in(ch_lvl[ch]),
				.level_mode(icfg_reg[ch][gpio_pkg::ICFG_LEVEL_BIT]),
				.active_high(icfg_reg[ch][gpio_pkg::ICFG_HIGH_BIT]),
				.clr(ch_clr[ch]),
				.irq(ch_irq[ch]),
				.pending(ch_pend[ch])
			);
		end
		// Per-port group terms: any enabled pin, or every enabled pin, at its active level.
		for (ch = 0; ch < gpio_pkg::PORTS; ch = ch + 1) begin : g_port
			assign g0_hit[ch] = |(g0en_reg[ch] & ~(pin_lvl[ch] ^ g0pol_reg[ch]));
			assign g1_hit[ch] = |(g1en_reg[ch] & ~(pin_lvl[ch] ^ g1pol_reg[ch]));
			assign g0_ok[ch] = &(~g0en_reg[ch] | ~(pin_lvl[ch] ^ g0pol_reg[ch]));
			assign g1_ok[ch] = &(~g1en_reg[ch] | ~(pin_lvl[ch] ^ g1pol_reg[ch]));
		end
	endgenerate

	// AND mode needs every enabled pin active and at least one enabled.
	assign grp_next[0] = gand_reg[0] ? (&g0_ok && |g0en_reg) : |g0_hit;
	assign grp_next[1] = gand_reg[1] ? (&g1_ok && |g1en_reg) : |g1_hit;

	// Group interrupt outputs, level following the pins.
	always_ff @(posedge clk) begin
		if (rst) begin
			grp_reg <= '0;
		end else begin
			grp_reg <= grp_next;
		end
	end

	assign rsp = rsp_reg;
	assign pin_out = out_reg;
	assign pin_oe = oe_reg;
	assign pin_irq = ch_irq;
	assign group_irq = grp_reg;

endmodule : fast_gpio_port

// ### pin_world.sv
// Far side of the pads: pull-ups, bench drivers and the block's own drive.
`timescale 1ns/1ps
module pin_world (
	input wire logic [7:0][30:0] pin_out,
	input wire logic [7:0][30:0] pin_oe,
	input wire logic [7:0][30:0] ext_en,
	input wire logic [7:0][30:0] ext_val,
	output logic [7:0][30:0] pin_in
);
	// A driven pad shows the latch; an undriven, released pad floats high.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en);
endmodule : pin_world

// ### fast_gpio_port_asserts.sv
// Concurrent checks on the access port and pad outputs of the port block.
`timescale 1ns/1ps
module fast_gpio_port_asserts (
	input wire logic clk,
	input wire logic rst,
	input gpio_pkg::acc_req_t req,
	input gpio_pkg::acc_rsp_t rsp,
	input wire logic [7:0][30:0] pin_in,
	input wire logic [7:0][30:0] pin_function_select_cfg,
	input wire logic [7:0][30:0] input_buffer_en,
	input wire logic [7:0][30:0] pin_out,
	input wire logic [7:0][30:0] pin_oe,
	input wire logic [7:0] pin_irq,
	input wire logic [1:0] group_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Whole-word set and clear writes; the port comes from idx.
	sequence s_set_word;
		req.wr && req.view == gpio_pkg::V_SET && req.be == 4'hF;
	endsequence
	sequence s_clr_word;
		req.wr && req.view == gpio_pkg::V_CLR && req.be == 4'hF;
	endsequence
	a_read_answer: assert property (req.rd |=> rsp.valid)
		else $error("read not answered");
	a_no_stray: assert property (!req.rd |=> !rsp.valid
		&& $stable(rsp.rdata)) else $error("read answer moved");
	a_reset_quiet: assert property ($fell(rst) |-> pin_out == '0
		&& pin_oe == '0 && pin_irq == '0 && group_irq == '0)
		else $error("outputs not cleared by reset");
	a_oe_selected: assert property ((pin_oe
		& ~$past(pin_function_select_cfg)) == '0)
		else $error("drive on an unselected pin");
	a_set_bits: assert property (s_set_word |=> pin_out[$past(req.idx)]
		== ($past(pin_out[req.idx]) | $past(req.wdata[30:0])))
		else $error("set write wrong");
	a_clr_bits: assert property (s_clr_word |=> pin_out[$past(req.idx)]
		== ($past(pin_out[req.idx]) & ~$past(req.wdata[30:0])))
		else $error("clear write wrong");
	a_lane_keep: assert property (req.wr && req.view == gpio_pkg::V_OUT
		&& req.be[3:2] == 2'h0 |=> pin_out[$past(req.idx)][30:16]
		== $past(pin_out[req.idx][30:16])) else $error("upper lanes moved");
	a_word_out: assert property (req.wr && req.view == gpio_pkg::V_OUT
		&& req.be == 4'hF |=> pin_out[$past(req.idx)]
		== $past(req.wdata[30:0])) else $error("word write wrong");
	a_pin_ro: assert property (req.wr && req.view == gpio_pkg::V_PIN
		|=> $stable(pin_out)) else $error("pin view write took effect");
endmodule : fast_gpio_port_asserts
bind fast_gpio_port fast_gpio_port_asserts u_chk (.clk(clk), .rst(rst),
	.req(req), .rsp(rsp), .pin_in(pin_in), .input_buffer_en(input_buffer_en),
	.pin_function_select_cfg(pin_function_select_cfg), .pin_out(pin_out),
	.pin_oe(pin_oe), .pin_irq(pin_irq), .group_irq(group_irq));

// ### test_fast_gpio_port.sv
// Self-checking bench: random register traffic, then pin interrupts.
`timescale 1ns/1ps
module test_fast_gpio_port;
	logic clk, rst;
	gpio_pkg::acc_req_t req;
	gpio_pkg::acc_rsp_t rsp;
	logic [7:0][30:0] pin_in, fsel, ibe, pin_out, pin_oe, ext_en, ext_val;
	logic [7:0] pin_irq;
	logic [1:0] group_irq;
	logic [30:0] m_dir [8], m_out [8], m_mask [8], bmv;
	logic [3:0] vt [7];
	logic [31:0] seed, w, d;
	logic [3:0] be;
	int fails, n_compared, i, k, p;
	fast_gpio_port dut (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
		.pin_in(pin_in), .pin_function_select_cfg(fsel),
		.input_buffer_en(ibe), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_irq(pin_irq), .group_irq(group_irq));
	pin_world u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [30:0] mg(input logic [30:0] o, n, m);
		return (o & ~m) | (n & m);
	endfunction : mg
	// Read level: own drive where enabled, else the pull-up, buffer gated.
	function automatic logic [31:0] exp_rd(input logic [3:0] v, input int q);
		logic [30:0] o, l;
		o = m_dir[q] & fsel[q];
		l = ((o & m_out[q]) | ~o) & ibe[q];
		case (v)
			gpio_pkg::V_DIR: return {1'b0, m_dir[q]};
			gpio_pkg::V_MASK: return {1'b0, m_mask[q]};
			gpio_pkg::V_PIN: return {1'b0, l};
			gpio_pkg::V_MPIN: return {1'b0, l & ~m_mask[q]};
			default: return {1'b0, m_out[q]};
		endcase
	endfunction : exp_rd
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask : chk
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	// One access, driven between falling edges so one rising edge takes it.
	task automatic acc(input logic wr, input logic [3:0] v, input int q,
		input logic [3:0] b, input logic [31:0] wd);
		@(negedge clk);
		req = '{wr: wr, rd: !wr, view: v, idx: q[2:0], be: b, wdata: wd};
		@(negedge clk);
		req = '0;
	endtask : acc
	// The idle cycle first lets pads settle after a direction change.
	task automatic rd(input logic [3:0] v, input int q, output logic [31:0] r);
		int j;
		@(negedge clk);
		acc(1'b0, v, q, 4'h0, 32'h0);
		for (j = 0; j < 4 && rsp.valid !== 1'b1; j++)
			@(negedge clk);
		if (rsp.valid !== 1'b1) begin
			fails++;
			complete_run();
		end
		r = rsp.rdata;
	endtask : rd
	task automatic wait_irq(input logic [9:0] m, v);
		int j;
		for (j = 0; j < 8 && ({group_irq, pin_irq} & m) !== v; j++)
			@(negedge clk);
		chk("irq", {22'h0, v}, {22'h0, {group_irq, pin_irq} & m});
		if (({group_irq, pin_irq} & m) !== v)
			complete_run();
	endtask : wait_irq
	// Free-running 25 MHz clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Main sequence: reset state, random traffic, interrupt channels.
	initial begin
		seed = 32'hEF0ADCB1;
		req = '0;
		ext_en = '0;
		ext_val = '0;
		ibe = '0;
		fails = 0;
		n_compared = 0;
		m_dir = '{default: '0};
		m_out = '{default: '0};
		m_mask = '{default: '0};
		vt = '{gpio_pkg::V_OUT, gpio_pkg::V_SET, gpio_pkg::V_CLR,
			gpio_pkg::V_DIR, gpio_pkg::V_MASK, gpio_pkg::V_MPIN,
			gpio_pkg::V_PIN};
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			fsel[i] = seed[30:0];
		end
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		chk("oe", 32'h0, {1'b0, pin_oe[0]});
		rd(gpio_pkg::V_DIR, 3, d);
		chk("dir", 32'h0, d);
		rd(gpio_pkg::V_PIN, 0, d);
		chk("pin", 32'h0, d);
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			ibe[i] = seed[30:0];
		end
		rd(gpio_pkg::V_PIN, 0, d);
		chk("pin", exp_rd(gpio_pkg::V_PIN, 0), d);
		for (i = 0; i < 300; i++) begin
			seed = xs(seed);
			p = seed[2:0];
			be = (i % 8 == 0) ? 4'hF : seed[6:3];
			k = seed[15:8] % 7;
			w = xs(seed);
			seed = w;
			bmv = 31'({{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}});
			acc(1'b1, vt[k], p, be, w);
			case (k)
				0: m_out[p] = mg(m_out[p], w[30:0], bmv);
				1: m_out[p] = mg(m_out[p], '1, w[30:0] & bmv);
				2: m_out[p] = mg(m_out[p], '0, w[30:0] & bmv);
				3: m_dir[p] = mg(m_dir[p], w[30:0], bmv);
				4: m_mask[p] = mg(m_mask[p], w[30:0], bmv);
				5: m_out[p] = mg(m_out[p], w[30:0], bmv & ~m_mask[p]);
				default: ;
			endcase
			rd(vt[k], p, d);
			chk("view", exp_rd(vt[k], p), d);
			rd(gpio_pkg::V_PIN, p, d);
			chk("pin", exp_rd(gpio_pkg::V_PIN, p), d);
			chk("oe", {1'b0, m_dir[p] & fsel[p]}, {1'b0, pin_oe[p]});
			chk("out", {1'b0, m_out[p]}, {1'b0, pin_out[p]});
		end
		acc(1'b1, gpio_pkg::V_DIR, 0, 4'hF, 32'h0);
		ibe[0][3] = 1'b1;
		ext_en[0][3] = 1'b1;
		ext_val[0][3] = 1'b0;
		acc(1'b1, gpio_pkg::V_ICFG, 0, 4'h3, 32'h203);
		acc(1'b1, gpio_pkg::V_ICFG, 1, 4'h3, 32'h103);
		acc(1'b1, gpio_pkg::V_G0EN, 0, 4'hF, 32'h8);
		acc(1'b1, gpio_pkg::V_G0POL, 0, 4'hF, 32'h8);
		acc(1'b1, gpio_pkg::V_GCTL, 0, 4'hF, 32'h0);
		acc(1'b1, gpio_pkg::V_ICLR, 0, 4'h1, 32'h1);
		wait_irq(10'h103, 10'h002);
		ext_val[0][3] = 1'b1;
		wait_irq(10'h103, 10'h101);
		// The rising edge on channel 0 must leave its pending bit set.
		rd(gpio_pkg::V_ISTAT, 0, d);
		chk("istat", 32'h1, d & 32'h1);
		acc(1'b1, gpio_pkg::V_ICLR, 0, 4'h1, 32'h1);
		wait_irq(10'h003, 10'h000);
		// Group 1 in AND mode: pin 3 high alone must not fire it.
		ibe[0][4] = 1'b1;
		ext_en[0][4] = 1'b1;
		ext_val[0][4] = 1'b0;
		acc(1'b1, gpio_pkg::V_G1EN, 0, 4'hF, 32'h18);
		acc(1'b1, gpio_pkg::V_G1POL, 0, 4'hF, 32'h18);
		acc(1'b1, gpio_pkg::V_GCTL, 0, 4'h1, 32'h2);
		wait_irq(10'h200, 10'h000);
		ext_val[0][4] = 1'b1;
		wait_irq(10'h200, 10'h200);
		complete_run();
	end
endmodule : test_fast_gpio_port
